// [hdsp_mstr.sv]
/* master station model: frames on RXD, reads TXD, drives CTS.
   assumes 8 data bits, optional even parity, one stop bit, and the bench clock. */
`timescale 1ns/100ps
module hdsp_mstr (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o,
    output logic      cts_o
);
    int   bit_cyc = 64;   // bench keeps this equal to the slave's bit period
    int   par_bad = 0;    // parity errors seen on TXD
    logic par     = 1'b0; // even parity in both directions when set
    logic rxd_q   = 1'b1; // idle mark level
    logic cts_q   = 1'b0; // modem raises it only when ready
    assign rxd_o = rxd_q;
    assign cts_o = cts_q;
    // ==========
    // frame out, lsb first, one stop bit
    task automatic put(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, par ? ^b : 1'b1, b, 1'b0};
        for (int i = 0; i < (par ? 11 : 10); i++) begin
            rxd_q <= f[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
    endtask
    // bounded wait for a start bit, then sample mid-bit
    task automatic get(input int lim, output logic [7:0] b, output logic got);
        b = 8'h00;
        while (txd_i !== 1'b0 && lim > 0) begin
            @(posedge clk_i);
            lim--;
        end
        got = (txd_i === 1'b0);
        if (got) begin
            repeat (bit_cyc / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge clk_i);
                b[i] = txd_i;
            end
            repeat (bit_cyc) @(posedge clk_i);
            if (par) begin
                if (txd_i !== ^b) par_bad++;
                repeat (bit_cyc) @(posedge clk_i);
            end
        end
    endtask
endmodule

// [hdsp_pkg.sv]
/*
 * constants, register map and state type for the half-duplex slave serial port.
 * assumes a single 100 MHz clock and a 32-bit ahb-lite register bus.
 */
package hdsp_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int unsigned BAUD_BASE     = 300;
    localparam int unsigned BIT300_CYC    = CLK_HZ / BAUD_BASE;
    localparam int unsigned MS_TICK_NS    = 1_000_000;
    localparam int unsigned MS_TICK_CYC   = MS_TICK_NS / CLK_PERIOD_NS;
    localparam logic [4:0]  LONG_TICK_MS  = 5'h14;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATION  = 8'h04;
    localparam logic [7:0] OFS_POLL_TO  = 8'h08;
    localparam logic [7:0] OFS_RTS_OFF  = 8'h0c;
    localparam logic [7:0] OFS_RTS_SEND = 8'h10;
    localparam logic [7:0] OFS_PRE_TX   = 8'h14;
    localparam logic [7:0] OFS_RETRIES  = 8'h18;
    localparam logic [7:0] OFS_MSG      = 8'h1c;
    localparam logic [7:0] OFS_RXDATA   = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;
    localparam logic [7:0] OFS_MASK     = 8'h28;
    // ==========================================================
    // control fields and reset values
    localparam int unsigned CTRL_BAUD_LSB = 0;
    localparam int unsigned CTRL_PAR_EN   = 3;
    localparam int unsigned CTRL_MODEM    = 4;
    localparam int unsigned CTRL_EOT_SUP  = 5;
    localparam int unsigned CTRL_DUP_EN   = 6;
    localparam int unsigned MSG_PEND_BIT  = 8;
    localparam logic [6:0]  CTRL_RST      = 7'h00;
    localparam logic [7:0]  STATION_RST   = 8'h00;
    localparam logic [7:0]  STATION_MAX   = 8'hfe;
    localparam logic [15:0] DELAY_RST     = 16'h0000;
    localparam logic [7:0]  RETRIES_RST   = 8'h00;
    // ==========================================================
    // status bits (same layout in mask)
    localparam int unsigned ST_RX_DATA  = 0;
    localparam int unsigned ST_MSG_DONE = 1;
    localparam int unsigned ST_MSG_TOUT = 2;
    localparam int unsigned ST_MSG_NACK = 3;
    localparam int unsigned ST_DUP      = 4;
    localparam int unsigned ST_W        = 5;
    // ==========================================================
    // packet: station byte, kind byte (bit 7 = sequence), payload byte
    localparam logic [6:0] KIND_POLL = 7'h01;
    localparam logic [6:0] KIND_ACK  = 7'h02;
    localparam logic [6:0] KIND_DATA = 7'h03;
    localparam logic [6:0] KIND_EOT  = 7'h04;
    localparam logic [1:0] PKT_LAST  = 2'h2;
    localparam logic [1:0] PKT_LEN   = 2'h3;

    typedef enum logic [2:0] {
        TS_IDLE     = 3'b000,
        TS_PRE      = 3'b001,
        TS_SEND_DLY = 3'b010,
        TS_CTS      = 3'b011,
        TS_SEND     = 3'b100,
        TS_OFF      = 3'b101
    } hdsp_txst_t;
endpackage

// [hdsp_top.sv]
/*
 * half-duplex polled slave serial port: uart, packet handler, rts/cts
 * sequencing, message retry and poll timeout, ahb-lite registers.
 * assumes inputs are synchronous to CLK_I and a single-master ahb-lite bus.
 */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
// Overview of operation
// - eight baud rates, none or even parity
// - station address zero to 254 as source
// - eot suppression: no reply when nothing queued
// - duplicate packets detected and discarded
// - poll timeout runs only with pending message
// - timeout drops message and flags error
// - zero poll timeout disables it
// - rts held for off delay after last character
// - wait send delay before sampling cts
// - resend unacknowledged message up to retry count
// - no handshaking: pre-transmit delay before sending
// - modem: pre-transmit delay from receive to rts
module hdsp_top #(
    parameter int unsigned BIT300_CYC   = hdsp_pkg::BIT300_CYC,
    parameter int unsigned MS_TICK_CYC  = hdsp_pkg::MS_TICK_CYC
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        RXD_I,
    output logic             TXD_O,
    output logic             RTS_O,
    input  wire logic        CTS_I,
    output logic             IRQ_O
);
    import hdsp_pkg::*;

    // bit period: the rates are 300 times a power of two
    function automatic logic [18:0] bit_period(input logic [2:0] sel);
        bit_period = 19'(BIT300_CYC >> sel);
    endfunction

    logic [6:0]  ctrl_ff;
    logic [7:0]  station_ff, retries_ff, msg_data_ff, rx_data_ff;
    logic [15:0] poll_to_ff, rts_off_ff, rts_send_ff, pre_tx_ff;
    logic [ST_W-1:0] status_ff, mask_ff, evt;
    logic        pend_ff, await_ff, msg_seq_ff, dup_seq_ff, dup_vld_ff;
    logic        wr_ph_ff, rd_ok;
    logic [7:0]  wa_ff;
    logic        msg_wr, byte_vld, timeout_evt, poll_hit, send_req;
    logic [6:0]  send_kind;
    logic [7:0]  retry_cnt_ff, send_pay;
    logic [18:0] bitc;

    assign bitc = bit_period(ctrl_ff[CTRL_BAUD_LSB +: 3]);

    // ==========================================================
    // ahb-lite slave: zero wait state, always okay
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wr_ph_ff    <= 1'b0;
            wa_ff       <= 8'h00;
            HREADYOUT_O <= 1'b0;
            HRESP_O     <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_ph_ff    <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I
                           && (HSIZE_I == 3'h2);
            wa_ff       <= HADDR_I[7:0];
        end
    end

    assign rd_ok  = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
    assign msg_wr = wr_ph_ff && (wa_ff == OFS_MSG);

    // read data is captured in the address phase so it stands in the data phase
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (rd_ok && HADDR_I[31:8] == 24'h00_0000) begin
            case (HADDR_I[7:0])
                OFS_CTRL:     HRDATA_O <= {25'h0, ctrl_ff};
                OFS_STATION:  HRDATA_O <= {24'h0, station_ff};
                OFS_POLL_TO:  HRDATA_O <= {16'h0, poll_to_ff};
                OFS_RTS_OFF:  HRDATA_O <= {16'h0, rts_off_ff};
                OFS_RTS_SEND: HRDATA_O <= {16'h0, rts_send_ff};
                OFS_PRE_TX:   HRDATA_O <= {16'h0, pre_tx_ff};
                OFS_RETRIES:  HRDATA_O <= {24'h0, retries_ff};
                OFS_MSG:      HRDATA_O <= {23'h0, pend_ff, msg_data_ff};
                OFS_RXDATA:   HRDATA_O <= {24'h0, rx_data_ff};
                OFS_STATUS:   HRDATA_O <= {27'h0, status_ff};
                OFS_MASK:     HRDATA_O <= {27'h0, mask_ff};
                default:      HRDATA_O <= 32'h0000_0000;
            endcase
        end else begin
            HRDATA_O <= 32'h0000_0000;
        end
    end

    // configuration registers; a station above 254 is refused
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_ff     <= CTRL_RST;
            station_ff  <= STATION_RST;
            poll_to_ff  <= DELAY_RST;
            rts_off_ff  <= DELAY_RST;
            rts_send_ff <= DELAY_RST;
            pre_tx_ff   <= DELAY_RST;
            retries_ff  <= RETRIES_RST;
            msg_data_ff <= 8'h00;
            mask_ff     <= '0;
        end else if (wr_ph_ff) begin
            case (wa_ff)
                OFS_CTRL:     ctrl_ff <= HWDATA_I[6:0];
                OFS_STATION:  if (HWDATA_I[7:0] <= STATION_MAX)
                    station_ff <= HWDATA_I[7:0];
                OFS_POLL_TO:  poll_to_ff  <= HWDATA_I[15:0];
                OFS_RTS_OFF:  rts_off_ff  <= HWDATA_I[15:0];
                OFS_RTS_SEND: rts_send_ff <= HWDATA_I[15:0];
                OFS_PRE_TX:   pre_tx_ff   <= HWDATA_I[15:0];
                OFS_RETRIES:  retries_ff  <= HWDATA_I[7:0];
                OFS_MSG:      msg_data_ff <= HWDATA_I[7:0];
                OFS_MASK:     mask_ff     <= HWDATA_I[ST_W-1:0];
                default:      ;
            endcase
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status_ff <= '0;
            IRQ_O     <= 1'b0;
        end else begin
            if (wr_ph_ff && wa_ff == OFS_STATUS)
                status_ff <= (status_ff & ~HWDATA_I[ST_W-1:0]) | evt;
            else
                status_ff <= status_ff | evt;
            IRQ_O <= |(status_ff & mask_ff);
        end
    end

    // ==========================================================
    // timebase: 1 ms tick and 20 ms tick
    logic [16:0] ms_cnt_ff;
    logic [4:0]  lt_cnt_ff;
    logic        tick_ms, tick_lt;
    assign tick_ms = (ms_cnt_ff == 17'(MS_TICK_CYC - 1));
    assign tick_lt = tick_ms && (lt_cnt_ff == LONG_TICK_MS - 5'h1);
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ms_cnt_ff <= '0;
            lt_cnt_ff <= '0;
        end else begin
            ms_cnt_ff <= tick_ms ? 17'h0 : ms_cnt_ff + 17'h1;
            if (tick_ms)
                lt_cnt_ff <= tick_lt ? 5'h0 : lt_cnt_ff + 5'h1;
        end
    end

    // ==========================================================
    // receiver: start, 8 data lsb first, optional even parity, stop
    logic [18:0] rx_tmr_ff;
    logic [3:0]  rx_idx_ff;
    logic        rx_act_ff, rx_stop;
    logic [8:0]  rx_sh_ff;
    logic [7:0]  rx_byte_ff;
    logic        rx_vld_ff;
    assign rx_stop  = (rx_idx_ff == (ctrl_ff[CTRL_PAR_EN] ? 4'ha : 4'h9));
    assign byte_vld = rx_vld_ff;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_act_ff <= 1'b0;
            rx_tmr_ff <= '0;
            rx_idx_ff <= '0;
            rx_sh_ff  <= '0;
            rx_byte_ff <= 8'h00;
            rx_vld_ff <= 1'b0;
        end else begin
            rx_vld_ff <= 1'b0;
            if (!rx_act_ff) begin
                if (!RXD_I) begin
                    rx_act_ff <= 1'b1;
                    rx_tmr_ff <= bitc >> 1;
                    rx_idx_ff <= 4'h0;
                end
            end else if (rx_tmr_ff != 19'h0) begin
                rx_tmr_ff <= rx_tmr_ff - 19'h1;
            end else begin
                rx_tmr_ff <= bitc - 19'h1;
                rx_idx_ff <= rx_idx_ff + 4'h1;
                if (rx_idx_ff == 4'h0 && RXD_I) begin
                    rx_act_ff <= 1'b0; // false start
                end else if (rx_stop) begin
                    rx_act_ff <= 1'b0;
                    // a byte with bad parity or framing is dropped silently
                    if (RXD_I && (!ctrl_ff[CTRL_PAR_EN] || !(^rx_sh_ff))) begin
                        rx_vld_ff  <= 1'b1;
                        rx_byte_ff <= ctrl_ff[CTRL_PAR_EN] ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
                    end
                end else if (rx_idx_ff != 4'h0) begin
                    rx_sh_ff <= {RXD_I, rx_sh_ff[8:1]};
                end
            end
        end
    end

    // ==========================================================
    // packet assembly; a silent millisecond resynchronises the byte index
    logic [1:0] pk_idx_ff;
    logic [7:0] pk_st_ff, pk_kind_ff;
    logic       pk_seen_ff, pk_done_ff;
    logic [7:0] pk_pay_ff;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pk_idx_ff <= '0;
            pk_st_ff <= 8'h00;
            pk_kind_ff <= 8'h00;
            pk_pay_ff <= 8'h00;
            pk_seen_ff <= 1'b0;
            pk_done_ff <= 1'b0;
        end else begin
            pk_done_ff <= 1'b0;
            if (byte_vld) begin
                pk_seen_ff <= 1'b1;
                pk_idx_ff  <= (pk_idx_ff == PKT_LAST) ? 2'h0 : pk_idx_ff + 2'h1;
                case (pk_idx_ff)
                    2'h0:    pk_st_ff <= rx_byte_ff;
                    2'h1:    pk_kind_ff <= rx_byte_ff;
                    default: begin
                        pk_pay_ff  <= rx_byte_ff;
                        pk_done_ff <= 1'b1;
                    end
                endcase
            end else if (tick_ms) begin
                if (!pk_seen_ff && !rx_act_ff)
                    pk_idx_ff <= 2'h0;
                pk_seen_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // message handling: replies, retries, duplicates, poll timeout
    hdsp_txst_t st_ff;
    logic [15:0] pto_cnt_ff;
    logic        hit, is_poll, is_ack, is_data, is_dup;
    assign hit     = pk_done_ff && (pk_st_ff == station_ff);
    assign is_poll = hit && pk_kind_ff[6:0] == KIND_POLL;
    assign is_ack  = hit && pk_kind_ff[6:0] == KIND_ACK;
    assign is_data = hit && pk_kind_ff[6:0] == KIND_DATA;
    assign is_dup  = ctrl_ff[CTRL_DUP_EN] && dup_vld_ff && pk_kind_ff[7] == dup_seq_ff;
    assign poll_hit = is_poll;
    assign timeout_evt = pend_ff && poll_to_ff != 16'h0
                         && pto_cnt_ff == poll_to_ff;

    always_comb begin
        send_req  = 1'b0;
        send_kind = KIND_EOT;
        send_pay  = 8'h00;
        evt       = '0;
        evt[ST_RX_DATA]  = is_data && !is_dup;
        evt[ST_DUP]      = is_data && is_dup;
        evt[ST_MSG_DONE] = is_ack && await_ff;
        evt[ST_MSG_TOUT] = timeout_evt;
        if (is_poll && st_ff == TS_IDLE) begin
            if (pend_ff && await_ff && retry_cnt_ff >= retries_ff) begin
                evt[ST_MSG_NACK] = 1'b1;
            end else if (pend_ff) begin
                send_req  = 1'b1;
                send_kind = KIND_DATA;
                send_pay  = msg_data_ff;
            end else begin
                send_req  = !ctrl_ff[CTRL_EOT_SUP];
            end
        end
    end

    // pending message; a software write wins over a same-cycle drop
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pend_ff <= 1'b0;
            await_ff <= 1'b0;
            msg_seq_ff <= 1'b0;
            retry_cnt_ff <= 8'h00;
        end else begin
            if (evt[ST_MSG_DONE])
                msg_seq_ff <= !msg_seq_ff;
            if (msg_wr) begin
                pend_ff <= 1'b1;
                await_ff <= 1'b0;
                retry_cnt_ff <= 8'h00;
            end else if (evt[ST_MSG_DONE] || evt[ST_MSG_TOUT] || evt[ST_MSG_NACK]) begin
                pend_ff <= 1'b0;
                await_ff <= 1'b0;
            end else if (send_req && send_kind == KIND_DATA) begin
                await_ff <= 1'b1;
                if (await_ff)
                    retry_cnt_ff <= retry_cnt_ff + 8'h1;
            end
        end
    end

    // poll timeout counts 20 ms ticks only while a message is pending
    always_ff @(posedge CLK_I) begin
        if (RST_I || !pend_ff || poll_hit || msg_wr)
            pto_cnt_ff <= 16'h0;
        else if (tick_lt && pto_cnt_ff != 16'hffff)
            pto_cnt_ff <= pto_cnt_ff + 16'h1;
    end

    // accepted data and duplicate tracking
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_data_ff <= 8'h00;
            dup_seq_ff <= 1'b0;
            dup_vld_ff <= 1'b0;
        end else if (evt[ST_RX_DATA]) begin
            rx_data_ff <= pk_pay_ff;
            dup_seq_ff <= pk_kind_ff[7];
            dup_vld_ff <= 1'b1;
        end
    end

    // ==========================================================
    // transmit sequencer: pre delay, rts, send delay, cts, bytes, off delay
    logic [15:0] dly_ff;
    logic [7:0]  tx_kind_ff, tx_pay_ff;
    logic [1:0]  tx_idx_ff;
    logic        tx_busy_ff, tx_go;
    logic        modem;
    assign modem = ctrl_ff[CTRL_MODEM];
    assign tx_go = st_ff == TS_SEND && !tx_busy_ff && tx_idx_ff != PKT_LEN;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_ff <= TS_IDLE;
            dly_ff <= 16'h0;
            RTS_O <= 1'b0;
            tx_kind_ff <= 8'h00;
            tx_pay_ff <= 8'h00;
            tx_idx_ff <= 2'h0;
        end else begin
            case (st_ff)
                TS_IDLE: if (send_req) begin
                    st_ff <= TS_PRE;
                    dly_ff <= 16'h0;
                    tx_kind_ff <= {send_kind == KIND_DATA && msg_seq_ff, send_kind};
                    tx_pay_ff <= send_pay;
                end
                // the request comes at the last received character
                TS_PRE: if (dly_ff == pre_tx_ff) begin
                    st_ff <= modem ? TS_SEND_DLY : TS_SEND;
                    RTS_O <= modem;
                    dly_ff <= 16'h0;
                    tx_idx_ff <= 2'h0;
                end else if (tick_ms) dly_ff <= dly_ff + 16'h1;
                TS_SEND_DLY: if (dly_ff == rts_send_ff) begin
                    st_ff <= TS_CTS;
                end else if (tick_lt) dly_ff <= dly_ff + 16'h1;
                // a modem that never raises cts stalls the reply here
                TS_CTS: if (CTS_I) st_ff <= TS_SEND;
                TS_SEND: if (tx_go) begin
                    tx_idx_ff <= tx_idx_ff + 2'h1;
                end else if (tx_idx_ff == PKT_LEN && !tx_busy_ff) begin
                    st_ff <= modem ? TS_OFF : TS_IDLE;
                    dly_ff <= 16'h0;
                end
                TS_OFF: if (dly_ff == rts_off_ff) begin
                    st_ff <= TS_IDLE;
                    RTS_O <= 1'b0;
                end else if (tick_lt) dly_ff <= dly_ff + 16'h1;
                default: st_ff <= TS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // transmitter shift register; busy covers the whole stop bit
    logic [18:0] tx_tmr_ff;
    logic [3:0]  tx_left_ff;
    logic [9:0]  tx_sh_ff;
    logic [7:0]  tx_byte;
    always_comb begin
        case (tx_idx_ff)
            2'h0:    tx_byte = station_ff;
            2'h1:    tx_byte = tx_kind_ff;
            default: tx_byte = tx_pay_ff;
        endcase
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TXD_O <= 1'b1;
            tx_busy_ff <= 1'b0;
            tx_tmr_ff <= '0;
            tx_left_ff <= '0;
            tx_sh_ff <= '1;
        end else if (tx_go) begin
            TXD_O <= 1'b0;
            tx_busy_ff <= 1'b1;
            tx_tmr_ff <= bitc - 19'h1;
            tx_left_ff <= ctrl_ff[CTRL_PAR_EN] ? 4'ha : 4'h9;
            tx_sh_ff <= {1'b1, ctrl_ff[CTRL_PAR_EN] ? ^tx_byte : 1'b1, tx_byte};
        end else if (tx_busy_ff) begin
            if (tx_tmr_ff != 19'h0) begin
                tx_tmr_ff <= tx_tmr_ff - 19'h1;
            end else if (tx_left_ff == 4'h0) begin
                tx_busy_ff <= 1'b0;
            end else begin
                TXD_O <= tx_sh_ff[0];
                tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                tx_left_ff <= tx_left_ff - 4'h1;
                tx_tmr_ff <= bitc - 19'h1;
            end
        end else begin
            TXD_O <= 1'b1;
        end
    end

    // ==========================================================
    // checks
    station_lim_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        station_ff <= STATION_MAX) else $error("station above 254");
    eot_quiet_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (is_poll && !pend_ff && ctrl_ff[CTRL_EOT_SUP] && st_ff == TS_IDLE) |=> st_ff == TS_IDLE)
        else $error("reply sent under eot suppression");
    dup_drop_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        evt[ST_DUP] |=> $stable(rx_data_ff)) else $error("duplicate accepted");
    pto_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        poll_to_ff == 16'h0 |-> !evt[ST_MSG_TOUT]) else $error("timeout while disabled");
    pto_drop_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (timeout_evt && !msg_wr) |=> !pend_ff && status_ff[ST_MSG_TOUT])
        else $error("timeout did not drop message");
    retry_lim_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == TS_IDLE && send_req && await_ff) |-> retry_cnt_ff < retries_ff)
        else $error("retry beyond count");
    cts_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == TS_CTS && !CTS_I) |=> st_ff == TS_CTS) else $error("sent without cts");
    send_dly_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == TS_SEND_DLY && dly_ff != rts_send_ff) |=> st_ff == TS_SEND_DLY)
        else $error("cts sampled early");
    rts_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == TS_OFF || (st_ff == TS_SEND && modem)) |-> RTS_O)
        else $error("rts dropped early");
    pre_dly_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == TS_PRE && dly_ff != pre_tx_ff) |=> st_ff == TS_PRE && !RTS_O)
        else $error("pre-transmit delay cut short");
endmodule

// [tb_top.sv]
/* bench: ahb-lite register tasks and a master station model.
   assumes hdsp_pkg and the design are compiled first. */
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("BAD %0t mismatch got %h want %h", $time, a, e); end end
module tb_top;
    import hdsp_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b000;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic        hrdy, hresp, txd, rts, irq, rxd, cts, got;
    logic [7:0]  b0, b1, b2;
    int          errors = 0, check_count = 0;
    always #5 clk = ~clk;
    hdsp_top #(.BIT300_CYC(64), .MS_TICK_CYC(50)) uut (
        .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .RXD_I(rxd), .TXD_O(txd),
        .RTS_O(rts), .CTS_I(cts), .IRQ_O(irq));
    hdsp_mstr m (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_o(cts));
    // ==========
    // single word transfer, address phase held until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hsize <= 3'b010;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic send(input logic [6:0] k);
        m.put(8'hfe);
        m.put({1'b0, k});
        m.put(8'h00);
    endtask
    task automatic rx3(input int lim);
        m.get(lim, b0, got);
        if (got) begin
            m.get(500, b1, got);
            m.get(500, b2, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // runs need about 40k cycles
    initial begin
        #1000000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, OFS_STATION, 32'hff);
        bus(1'b0, OFS_STATION, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, OFS_STATION, 32'hfe);
        bus(1'b0, 8'h3c, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b1, OFS_PRE_TX, 32'h2);
        m.bit_cyc = 32;
        send(KIND_POLL);
        `CHK(txd, 1'b1)
        rx3(300);
        `CHK({b0, b1[6:0], b2}, {8'hfe, KIND_EOT, 8'h00})
        bus(1'b1, OFS_CTRL, 32'h9);
        m.par = 1'b1;
        send(KIND_POLL);
        rx3(300);
        `CHK({got, b1, m.par_bad}, {1'b1, 8'h04, 32'd0})
        m.par = 1'b0;
        bus(1'b1, OFS_CTRL, 32'h20);
        m.bit_cyc = 64;
        send(KIND_POLL);
        rx3(2000);
        `CHK(got, 1'b0)
        $display("done eot");
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_MASK, 32'h2);
        bus(1'b1, OFS_MSG, 32'h5a);
        repeat (3000) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[2], 1'b0)
        send(KIND_POLL);
        rx3(300);
        `CHK({b1[6:0], b2}, {KIND_DATA, 8'h5a})
        send(KIND_ACK);
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, OFS_STATUS, 32'h2);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK({rd[1], irq}, 2'b00)
        $display("done message");
        bus(1'b1, OFS_CTRL, 32'h40);
        send(KIND_DATA);
        send(KIND_DATA);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK({rd[4], rd[0]}, 2'b11)
        bus(1'b1, OFS_RETRIES, 32'h1);
        bus(1'b1, OFS_MSG, 32'h33);
        for (int i = 0; i < 3; i++) begin
            send(KIND_POLL);
            rx3(300);
            `CHK(got, (i < 2))
        end
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[3], 1'b1)
        bus(1'b1, OFS_POLL_TO, 32'h2);
        bus(1'b1, OFS_MSG, 32'h44);
        repeat (2500) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        $display("done retry");
        bus(1'b1, OFS_RTS_SEND, 32'h1);
        bus(1'b1, OFS_RTS_OFF, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h10);
        send(KIND_POLL);
        repeat (1500) @(posedge clk);
        `CHK({rts, txd}, 2'b11)
        m.cts_q <= 1'b1;
        rx3(300);
        `CHK({got, rts}, 2'b11)
        repeat (2100) @(posedge clk);
        `CHK(rts, 1'b0)
        $display("done modem");
        end_sim();
    end
endmodule
